// ==== inc/dac_scale_pkg.sv ====
// Constants, register map and helpers for the bipolar output scaling datapath
package dac_scale_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_PD        = 6'h00;
  localparam logic [5:0] IDX_DAC       = 6'h01;
  localparam logic [5:0] IDX_COMP_OFS  = 6'h11;
  localparam logic [5:0] IDX_COMP_GAIN = 6'h12;
  localparam logic [5:0] IDX_FACT_OFS  = 6'h13;
  localparam logic [5:0] IDX_FACT_GAIN = 6'h14;
  localparam logic [5:0] IDX_FEATURE   = 6'h20;
  localparam logic [5:0] IDX_CUST_OFS  = 6'h21;
  localparam logic [5:0] IDX_CUST_GAIN = 6'h22;

  // ----------------------------------------------------------------
  // Feature register fields and reset values
  // ----------------------------------------------------------------
  localparam int FB_CUST_EN  = 0;
  localparam int FB_FACT_EN  = 1;
  localparam int FB_SIGN_MAG = 3;
  localparam int FB_VENDOR   = 5;

  localparam logic [15:0] FEATURE_RST = 16'h0002;
  localparam logic [15:0] UNITY_GAIN  = 16'h0100;
  localparam logic [15:0] OFS_RST     = 16'h0000;
  localparam logic [15:0] STATUS_MASK = 16'hfff8;
  localparam logic [11:0] DAC_RST     = 12'h800;
  localparam int          GAIN_SHIFT  = 8;
  localparam int          DAC_W       = 12;
  localparam int          DAC_STEPS   = 4095;
  localparam int          PIPE_LAT    = 5;

  typedef logic signed [15:0] sample_t;

  // Clamp a wide signed value into the 16-bit sample range
  function automatic sample_t sat16(input logic signed [24:0] v);
    if (v > 25'sh0007fff) begin
      sat16 = 16'sh7fff;
    end else if (v < -25'sh0008000) begin
      sat16 = -16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

endpackage

// ==== core/scale_stage.sv ====
// One straight-line scaling stage: y = offset + (gain * x) >> 8, saturated
`timescale 1ns/1ps
`default_nettype none

module scale_stage (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 valid_i,
  input  wire logic                 en_i,
  input  wire dac_scale_pkg::sample_t x_i,
  input  wire logic [15:0]          gain_i,
  input  wire logic [15:0]          offset_i,
  output logic                      valid_o,
  output dac_scale_pkg::sample_t    y_o
);
  import dac_scale_pkg::*;

  typedef struct packed {
    logic    vld;
    sample_t y;
  } stage_s;

  stage_s s_q;
  stage_s s_d;
  logic signed [31:0] prod;
  logic signed [24:0] sum;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  always_comb begin
    prod  = 32'(x_i * $signed(gain_i));
    sum   = 25'(signed'(prod[31:GAIN_SHIFT])) + 25'(signed'(offset_i)); // [RL17]
    s_d   = s_q;
    s_d.vld = valid_i;
    if (valid_i) begin
      s_d.y = en_i ? sat16(sum) : x_i; // [RL16]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign valid_o = s_q.vld;
  assign y_o     = s_q.y;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_STAGE_BYPASS: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
    (valid_i && !en_i) |=> (valid_o && y_o == $past(x_i)))
    else $error("disabled stage did not pass the value through");

  AST_STAGE_UNITY: assert property (@(posedge clk_i) disable iff (rst_i) // [RL17]
    (valid_i && en_i && gain_i == UNITY_GAIN && offset_i == OFS_RST) |=> (y_o == $past(x_i)))
    else $error("unity gain with zero offset changed the value");

endmodule

`default_nettype wire

// ==== core/dac_scale_top.sv ====
// Bipolar output scaling datapath with classic Wishbone configuration registers
//
// Behaviour
// (RL1) Output spans -10 V to +10 V through a 12-bit converter code.
// (RL2) By default process words are two's complement; 0xffff is minus one.
// (RL3) Feature register selects sign-magnitude or vendor format instead.
// (RL4) 0x8000 is minus full scale, 0 is zero, 0x7fff plus full scale.
// (RL5) No scaling enabled: code is value times compensation gain plus offset.
// (RL6) Factory scaling alone (default) runs before compensation.
// (RL7) Custom scaling alone runs before compensation.
// (RL8) Both enabled: factory, then custom, then compensation.
// (RL9) Coefficient registers sit at indices 17,18,19,20,33,34.
// (RL10) Feature register at index 32 chooses which stages are active.
// (RL11) Configuration path reads and writes every register; the converter code at index 1 is read-only here.
// (RL12) Fieldbus process data wins over a concurrent configuration access.
// (RL13) Feature bit 0 enables custom scaling (off), bit 1 factory (on).
// (RL14) Feature bit 3 sign-magnitude, bit 5 vendor format; both off.
// (RL15) Custom gain resets to 256, custom offset to zero.
// (RL16) Final result saturates into the converter range, never wraps.
// (RL17) Gains are fixed point, 256 is unity, product shifted right by 8.
`timescale 1ns/1ps
`default_nettype none

module dac_scale_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        pd_valid_i,
  input  wire logic [15:0] pd_data_i,
  output logic      [11:0] dac_code_o,
  output logic             dac_valid_o
);
  import dac_scale_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] pd;
    logic [15:0] comp_ofs;
    logic [15:0] comp_gain;
    logic [15:0] fact_ofs;
    logic [15:0] fact_gain;
    logic [15:0] feature;
    logic [15:0] cust_ofs;
    logic [15:0] cust_gain;
    logic        load;
    logic        ack;
    logic [31:0] rdat;
    logic [11:0] dac;
    logic        dac_vld;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic        wb_req;
  logic [5:0]  idx;
  sample_t     x_dec;
  logic        fact_vld;
  sample_t     fact_y;
  logic        cust_vld;
  sample_t     cust_y;
  logic        comp_vld;
  sample_t     comp_y;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] sel);
    wr16[7:0]  = sel[0] ? d[7:0]  : old[7:0];
    wr16[15:8] = sel[1] ? d[15:8] : old[15:8];
  endfunction

  // Process word into signed sample according to the feature bits
  function automatic sample_t decode(input logic [15:0] raw, input logic [15:0] feat);
    if (feat[FB_SIGN_MAG]) begin
      decode = raw[15] ? 16'(16'h0000 - {1'b0, raw[14:0]}) : {1'b0, raw[14:0]}; // [RL3]
    end else if (feat[FB_VENDOR]) begin
      decode = raw & STATUS_MASK; // [RL3]
    end else begin
      decode = raw; // [RL2]
    end
  endfunction

  assign idx    = adr_i[7:2];
  assign wb_req = cyc_i && stb_i && !s_q.ack;
  assign x_dec  = decode(s_q.pd, s_q.feature);

  // ----------------------------------------------------------------
  // Scaling chain: factory, custom, compensation
  // ----------------------------------------------------------------
  scale_stage u_fact (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .valid_i  (s_q.load),
    .en_i     (s_q.feature[FB_FACT_EN]),
    .x_i      (x_dec),
    .gain_i   (s_q.fact_gain),
    .offset_i (s_q.fact_ofs),
    .valid_o  (fact_vld),
    .y_o      (fact_y)
  ); // [RL6] [RL8]

  scale_stage u_cust (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .valid_i  (fact_vld),
    .en_i     (s_q.feature[FB_CUST_EN]),
    .x_i      (fact_y),
    .gain_i   (s_q.cust_gain),
    .offset_i (s_q.cust_ofs),
    .valid_o  (cust_vld),
    .y_o      (cust_y)
  ); // [RL7] [RL8]

  scale_stage u_comp (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .valid_i  (cust_vld),
    .en_i     (1'b1),
    .x_i      (cust_y),
    .gain_i   (s_q.comp_gain),
    .offset_i (s_q.comp_ofs),
    .valid_o  (comp_vld),
    .y_o      (comp_y)
  ); // [RL5]

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.ack     = 1'b0;
    s_d.load    = 1'b0;
    s_d.dac_vld = 1'b0;
    if (pd_valid_i) begin
      // Process data takes the cycle; a pending bus access waits
      s_d.pd   = pd_data_i; // [RL12]
      s_d.load = 1'b1;
    end else if (wb_req) begin
      s_d.ack  = 1'b1; // [RL11]
      s_d.rdat = 32'h0000_0000;
      case (idx)
        IDX_PD:        s_d.rdat[15:0] = s_q.pd;
        IDX_DAC:       s_d.rdat[11:0] = s_q.dac;
        IDX_COMP_OFS:  s_d.rdat[15:0] = s_q.comp_ofs; // [RL9]
        IDX_COMP_GAIN: s_d.rdat[15:0] = s_q.comp_gain;
        IDX_FACT_OFS:  s_d.rdat[15:0] = s_q.fact_ofs;
        IDX_FACT_GAIN: s_d.rdat[15:0] = s_q.fact_gain;
        IDX_FEATURE:   s_d.rdat[15:0] = s_q.feature;
        IDX_CUST_OFS:  s_d.rdat[15:0] = s_q.cust_ofs;
        IDX_CUST_GAIN: s_d.rdat[15:0] = s_q.cust_gain;
        default:       s_d.rdat = 32'h0000_0000;
      endcase
      if (we_i) begin
        case (idx)
          IDX_PD: begin
            s_d.pd   = wr16(s_q.pd, dat_i, sel_i);
            s_d.load = 1'b1;
          end
          IDX_COMP_OFS:  s_d.comp_ofs  = wr16(s_q.comp_ofs, dat_i, sel_i); // [RL9]
          IDX_COMP_GAIN: s_d.comp_gain = wr16(s_q.comp_gain, dat_i, sel_i);
          IDX_FACT_OFS:  s_d.fact_ofs  = wr16(s_q.fact_ofs, dat_i, sel_i);
          IDX_FACT_GAIN: s_d.fact_gain = wr16(s_q.fact_gain, dat_i, sel_i);
          IDX_FEATURE:   s_d.feature   = wr16(s_q.feature, dat_i, sel_i); // [RL10]
          IDX_CUST_OFS:  s_d.cust_ofs  = wr16(s_q.cust_ofs, dat_i, sel_i);
          IDX_CUST_GAIN: s_d.cust_gain = wr16(s_q.cust_gain, dat_i, sel_i);
          default: begin
          end
        endcase
      end
    end
    if (comp_vld) begin
      // Signed sample to offset-binary code: 0x000 is -10 V, 0xfff is +10 V
      s_d.dac     = {~comp_y[15], comp_y[14:4]}; // [RL1] [RL4]
      s_d.dac_vld = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q           <= '0;
      s_q.feature   <= FEATURE_RST; // [RL13] [RL14]
      s_q.comp_gain <= UNITY_GAIN;
      s_q.comp_ofs  <= OFS_RST;
      s_q.fact_gain <= UNITY_GAIN;
      s_q.fact_ofs  <= OFS_RST;
      s_q.cust_gain <= UNITY_GAIN; // [RL15]
      s_q.cust_ofs  <= OFS_RST;
      s_q.dac       <= DAC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign dat_o       = s_q.rdat;
  assign ack_o       = s_q.ack;
  assign dac_code_o  = s_q.dac;
  assign dac_valid_o = s_q.dac_vld;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic ident;
  assign ident = s_q.feature == FEATURE_RST && s_q.fact_gain == UNITY_GAIN &&
                 s_q.comp_gain == UNITY_GAIN && s_q.fact_ofs == OFS_RST &&
                 s_q.comp_ofs == OFS_RST;

  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) // [RL11]
    else $error("ack held for more than one cycle");

  AST_PD_PRIORITY: assert property (pd_valid_i |=> !ack_o) // [RL12]
    else $error("bus access answered while process data arrived");

  // ----------------------------------------------------------------
  // Reset values, looked at in the first cycle out of reset
  // ----------------------------------------------------------------
  AST_FEATURE_RST: assert property ($fell(rst_i) |-> s_q.feature == FEATURE_RST) // [RL13] [RL14]
    else $error("feature register reset value wrong");

  AST_CUST_RST: assert property ($fell(rst_i) |-> (s_q.cust_gain == UNITY_GAIN && s_q.cust_ofs == OFS_RST)) // [RL15]
    else $error("custom coefficients reset value wrong");

  AST_OUT_RST: assert property ($fell(rst_i) |-> (dac_code_o == DAC_RST && !ack_o && !dac_valid_o)) // [RL1]
    else $error("outputs not at their reset values after reset");

  // ----------------------------------------------------------------
  // Register path and data capture
  // ----------------------------------------------------------------
  AST_PD_CAPTURE: assert property (pd_valid_i |=> s_q.pd == $past(pd_data_i)) // [RL12]
    else $error("process word not captured when strobed");

  AST_UNMAPPED_RD: assert property ((wb_req && !we_i && !pd_valid_i && idx == 6'h3f) |=> (ack_o && dat_o == 32'h0000_0000)) // [RL11]
    else $error("unmapped index did not read as zero");

  AST_DAC_RO: assert property ((wb_req && we_i && !pd_valid_i && idx == IDX_DAC && !comp_vld)
                               |=> dac_code_o == $past(dac_code_o)) // [RL11]
    else $error("write to the converter code index changed the code");

  AST_VENDOR_FMT: assert property ((s_q.feature[FB_VENDOR] && !s_q.feature[FB_SIGN_MAG]) |->
                                   x_dec == (s_q.pd & STATUS_MASK)) // [RL3]
    else $error("vendor format decode wrong");

  AST_LATENCY: assert property (pd_valid_i |-> ##5 dac_valid_o) // [RL5]
    else $error("converter code not produced five cycles after data");

  AST_DEFAULT_FMT: assert property ((!s_q.feature[FB_SIGN_MAG] && !s_q.feature[FB_VENDOR]) |-> x_dec == s_q.pd) // [RL2]
    else $error("default format is not two's complement");

  AST_SIGN_MAG: assert property ((s_q.feature[FB_SIGN_MAG] && s_q.pd[15]) |->
                                 x_dec == 16'(16'h0000 - {1'b0, s_q.pd[14:0]})) // [RL3]
    else $error("sign-magnitude decode wrong");

  AST_CODE_MAP: assert property (dac_valid_o |-> dac_code_o == {~$past(comp_y[15]), $past(comp_y[14:4])}) // [RL1]
    else $error("converter code does not follow compensated value");

  AST_FULL_SCALE: assert property ((pd_valid_i && pd_data_i == 16'h7fff && ident && !cyc_i) ##1 (ident && !cyc_i)
                                   |-> ##4 dac_code_o == 12'hfff) // [RL4]
    else $error("plus full scale did not reach top code");

  AST_SATURATE: assert property ((comp_vld && comp_y == 16'sh7fff) |=> dac_code_o == 12'hfff) // [RL16]
    else $error("saturated value did not give top code");

  AST_FEATURE_WR: assert property ((wb_req && we_i && !pd_valid_i && idx == IDX_FEATURE && sel_i == 4'hf)
                                   |=> (ack_o && s_q.feature == $past(dat_i[15:0]))) // [RL10]
    else $error("feature write not taken");

  AST_COEF_RD: assert property ((wb_req && !we_i && !pd_valid_i && idx == IDX_COMP_GAIN)
                                |=> (ack_o && dat_o == {16'h0000, s_q.comp_gain})) // [RL9]
    else $error("compensation gain read wrong");

  COV_PD_LOAD: cover property (pd_valid_i ##5 dac_valid_o);
  COV_CONFLICT: cover property (wb_req && pd_valid_i ##1 !ack_o ##1 ack_o);
  COV_BOTH_STAGES: cover property (s_q.feature[FB_CUST_EN] && s_q.feature[FB_FACT_EN] && dac_valid_o);
  COV_CFG_FORCE: cover property (wb_req && we_i && idx == IDX_PD && !pd_valid_i);
  COV_SIGN_MAG: cover property (s_q.feature[FB_SIGN_MAG] && s_q.pd[15] && s_q.load);

endmodule

`default_nettype wire

// ==== tb/coupler_model.sv ====
// Fieldbus coupler model handing process words to the datapath
`timescale 1ns/1ps
`default_nettype none

module coupler_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        send_i,
  input  wire logic [15:0] word_i,
  output logic             pd_valid_o,
  output logic      [15:0] pd_data_o
);
  // Idle data toggles each cycle so a stale word never looks valid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_valid_o <= 1'b0;
      pd_data_o  <= 16'h0000;
    end else begin
      pd_valid_o <= send_i;
      pd_data_o  <= send_i ? word_i : ~pd_data_o;
    end
  end
endmodule
`default_nettype wire

// ==== tb/bipolar_dac_output_scaling_tb.sv ====
// Self-checking bench for the bipolar output scaling datapath
`timescale 1ns/1ps
`default_nettype none

module bipolar_dac_output_scaling_tb;
  import dac_scale_pkg::*;

  localparam logic [5:0]  REG_IDX [7] = '{IDX_COMP_OFS, IDX_COMP_GAIN, IDX_FACT_OFS, IDX_FACT_GAIN,
                                          IDX_FEATURE, IDX_CUST_OFS, IDX_CUST_GAIN};
  localparam logic [15:0] CORNER [6] = '{16'h8000, 16'hc001, 16'h0000, 16'h3fff, 16'h7fff, 16'hffff};
  localparam logic [11:0] CORNER_CODE [6] = '{12'h000, 12'h400, 12'h800, 12'hbff, 12'hfff, 12'h7ff};

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic        send  = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [15:0] word  = 16'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        pd_valid;
  logic        pd_prev = 1'b0;
  logic        dac_valid;
  logic [15:0] pd_data;
  logic [11:0] dac_code;
  logic [15:0] feat, comp_ofs, comp_gain, fact_ofs, fact_gain, cust_ofs, cust_gain, rd;
  int          mismatches = 0;
  int          num_checks = 0;
  int          n_codes = 0;
  integer      seed = 32'h53899553;

  always #2 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    pd_prev <= pd_valid;
    if (dac_valid === 1'b1) begin
      n_codes <= n_codes + 1;
    end
  end

  coupler_model coupler_model_inst (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .word_i(word),
    .pd_valid_o(pd_valid), .pd_data_o(pd_data));

  dac_scale_top dac_scale_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .pd_valid_i(pd_valid),
    .pd_data_i(pd_data), .dac_code_o(dac_code), .dac_valid_o(dac_valid));

  // ----
  // Checks and bus tasks
  // ----
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic timed_out(input string what);
    mismatches++;
    $display("ERROR %s expected response seen none", what);
    wrap_up();
  endtask

  task automatic check_reg(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_code(input string name, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wb_xfer(input logic w, input logic [5:0] idx, input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= {16'($random(seed)), d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) timed_out("ack");
    check_reg("pd_at_take", 16'h0000, {15'h0, pd_prev});
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic convert(input logic [15:0] w);
    int n0, n;
    n0 = n_codes;
    n = 0;
    send <= 1'b1;
    word <= w;
    @(posedge clk_i);
    send <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (n_codes == n0 && n < 20);
    if (n_codes == n0) timed_out("dac_valid");
  endtask

  task automatic sync_regs(input logic wr);
    logic [15:0] val [7];
    val = '{comp_ofs, comp_gain, fact_ofs, fact_gain, feat, cust_ofs, cust_gain};
    for (int i = 0; i < 7; i++) begin
      if (wr) wb_xfer(1'b1, REG_IDX[i], val[i], rd);
    end
    for (int i = 0; i < 7; i++) begin
      wb_xfer(1'b0, REG_IDX[i], 16'h0000, rd);
      check_reg("coef_reg", val[i], rd);
    end
  endtask

  function automatic logic signed [15:0] stage(input logic signed [15:0] x, g, o);
    longint v;
    v = longint'(o) + ((longint'(x) * longint'(g)) >>> 8);
    return (v > 32767) ? 16'sh7fff : (v < -32768) ? 16'sh8000 : 16'(v);
  endfunction

  function automatic logic [11:0] model(input logic [15:0] w);
    logic signed [15:0] x;
    logic signed [15:0] mag;
    mag = $signed({1'b0, w[14:0]});
    if (feat[FB_SIGN_MAG]) x = w[15] ? -mag : mag;
    else if (feat[FB_VENDOR]) x = w & 16'hfff8;
    else x = w;
    if (feat[FB_FACT_EN]) x = stage(x, fact_gain, fact_ofs);
    if (feat[FB_CUST_EN]) x = stage(x, cust_gain, cust_ofs);
    x = stage(x, comp_gain, comp_ofs);
    return {~x[15], x[14:4]};
  endfunction

  // ----
  // Main sequence
  // ----
  initial begin
    int n0, n;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    feat = 16'h0002;
    {comp_ofs, fact_ofs, cust_ofs} = '0;
    {comp_gain, fact_gain, cust_gain} = {3{16'h0100}};
    sync_regs(1'b0);
    $display("test reset done");
    foreach (CORNER[i]) begin
      convert(CORNER[i]);
      check_code("dac_corner", CORNER_CODE[i], dac_code);
    end
    $display("test full scale done");
    for (int it = 0; it < 12; it++) begin
      feat = (16'($random(seed)) & 16'hffc4) | {10'h0, it >= 4 && it < 8, 1'b0, it >= 8, 1'b0, 2'(it)};
      comp_gain = 16'h0080 + 16'($random(seed) & 255);
      fact_gain = 16'h0080 + 16'($random(seed) & 255);
      cust_gain = 16'h0080 + 16'($random(seed) & 255);
      comp_ofs = 16'($random(seed) % 1024);
      fact_ofs = 16'($random(seed) % 1024);
      cust_ofs = 16'($random(seed) % 1024);
      sync_regs(1'b1);
      repeat (4) begin
        convert(16'($random(seed)));
        check_code("dac_scaled", model(word), dac_code);
      end
    end
    $display("test scaling done");
    feat = 16'h0000;
    comp_gain = 16'h7fff;
    comp_ofs = 16'h7fff;
    sync_regs(1'b1);
    convert(16'h7fff);
    check_code("dac_sat_high", 12'hfff, dac_code);
    convert(16'h8000);
    check_code("dac_sat_low", 12'h000, dac_code);
    $display("test saturation done");
    n0 = n_codes;
    send <= 1'b1;
    word <= 16'h1234;
    @(posedge clk_i);
    fork
      begin
        repeat (3) @(posedge clk_i);
        send <= 1'b0;
      end
      wb_xfer(1'b0, IDX_COMP_GAIN, 16'h0000, rd);
    join
    check_reg("gain_during_burst", comp_gain, rd);
    n = 0;
    while (n_codes < n0 + 4 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    check_reg("burst_codes", 16'd4, 16'(n_codes - n0));
    check_code("burst_last", model(16'h1234), dac_code);
    $display("test priority done");
    wb_xfer(1'b1, 6'h3f, 16'h5a5a, rd);
    wb_xfer(1'b0, 6'h3f, 16'h0000, rd);
    check_reg("unmapped", 16'h0000, rd);
    $display("test unmapped done");
    wrap_up();
  end
endmodule
`default_nettype wire
